// ==== hw/dcp_pkg.sv ====
package dcp_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int TRIG_OUT_NS = 2000;
  localparam int TRIG_OUT_CYC = TRIG_OUT_NS / CLK_PERIOD_NS;
  localparam int LATENCY_NS = 5000;
  localparam int LATENCY_CYC = LATENCY_NS / CLK_PERIOD_NS;
  localparam int MIN_PULSE_NS = 1000;
  localparam int MIN_PULSE_CYC = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_CYC = 4;
  localparam logic [7:0] TRIG_OUT_LOAD = 8'(TRIG_OUT_CYC - 1);

  // ----------------------------------------------------------------------
  // Pins and register map
  // ----------------------------------------------------------------------
  localparam int NUM_PINS = 7;
  localparam int FUNC_W = 3;
  localparam int PIN_ERROR = 0;
  localparam int PIN_RETURN = 1;
  localparam int PIN_BLOCK = 2;
  localparam int AXI_ADDR_W = 5;
  localparam logic [4:0] REG_FUNC = 5'h00;
  localparam logic [4:0] REG_POL = 5'h04;
  localparam logic [4:0] REG_DATA = 5'h08;
  localparam logic [4:0] REG_BLOCK = 5'h0c;
  localparam logic [4:0] REG_STATUS = 5'h10;
  localparam logic [4:0] REG_TRIG = 5'h14;
  localparam logic [4:0] REG_CHAN = 5'h18;
  localparam int BLK_MODE_LSB = 0;
  localparam int BLK_CLEAR_BIT = 4;
  localparam int ST_ERR_BIT = 0;
  localparam int ST_BLOCK_BIT = 1;
  localparam int ST_QUES_BIT = 2;
  localparam int ST_LATCH_BIT = 3;
  localparam int ST_TRIGGER_OUT_FUNCTION_BIT = 4;
  localparam int ST_TRIG_LSB = 8;
  localparam int TRIG_FIRE_BIT = 0;
  localparam logic [20:0] FUNC_RST = 21'h000000;
  localparam logic [6:0] POL_RST = 7'h00;
  localparam logic [6:0] DATA_RST = 7'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    general_bidir_function,
    input_only_function,
    trigger_in_function,
    trigger_out_function,
    error_out_function,
    output_block_function
  } dcp_func_type;

  typedef enum logic [1:0] {
    block_off,
    block_live,
    block_latch
  } dcp_block_mode_type;

endpackage : dcp_pkg

// ==== hw/dcp_top.sv ====
`timescale 1ns/1ps
module dcp_top
  import dcp_pkg::*;
#(
  parameter int NCH = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NUM_PINS-1:0] pin_in,
  output logic [NUM_PINS-1:0] pin_out,
  output logic [NUM_PINS-1:0] pin_oe,
  input wire logic [NCH-1:0] protect_cond,
  input wire logic power_fail,
  input wire logic trig_event,
  input wire logic [1:0] nv_block_mode,
  output logic [1:0] block_mode,
  output logic [NUM_PINS-1:0] trig_in_pulse,
  output logic [NCH-1:0] chan_enable,
  output logic block_indicator,
  output logic ques_block_bit,
  output logic error_signal
);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  if (NCH < 1 || NCH > 32) begin : g_bad_nch
    $error("NCH must lie between 1 and 32.");
  end
  if (TRIG_OUT_CYC < 2 || TRIG_OUT_CYC > 256) begin : g_bad_pulse
    $error("Trigger output pulse does not fit the 8-bit counter.");
  end
  if (SYNC_CYC + 2 > LATENCY_CYC || SYNC_CYC > MIN_PULSE_CYC) begin : g_bad_lat
    $error("Input path is too slow for the pin latency.");
  end

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_have;
    logic [AXI_ADDR_W-1:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [20:0] func;
    logic [6:0] pol;
    logic [6:0] out_word;
    dcp_block_mode_type mode;
    logic mode_loaded;
    logic clear_prot;
    logic [NCH-1:0] chan_on;
    logic [NCH-1:0] held;
    logic [NCH-1:0] chan_en;
    logic [6:0] sync1;
    logic [6:0] sync2;
    logic [6:0] sync3;
    logic [6:0] lvl;
    logic [6:0] prev_lvl;
    logic [6:0] trig_sticky;
    logic [6:0] trig_pulse;
    logic sw_trig;
    logic [7:0] tcnt;
    logic tactive;
    logic err;
    logic prev_inh;
    logic inh_latch;
    logic block;
    logic ques;
    logic [6:0] pin_out;
    logic [6:0] pin_oe;
  } dcp_state_type;

  dcp_state_type s;
  dcp_state_type next_s;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------

  // Merges write data into an old word under the byte strobes.
  function automatic logic [31:0] dcp_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction : dcp_merge

  // Returns the function code of one pin.
  function automatic dcp_func_type dcp_pin_func(input logic [20:0] v, input int idx);
    return dcp_func_type'(v[idx*FUNC_W +: FUNC_W]);
  endfunction : dcp_pin_func

  // Tells whether a byte address hits a mapped register.
  function automatic logic dcp_mapped(input logic [AXI_ADDR_W-1:0] a);
    logic [4:0] w;
    w = {a[4:2], 2'b00};
    return (w == REG_FUNC) || (w == REG_POL) || (w == REG_DATA) || (w == REG_BLOCK) ||
           (w == REG_STATUS) || (w == REG_TRIG) || (w == REG_CHAN);
  endfunction : dcp_mapped

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------

  // Computes the whole next state from the present one and the inputs.
  always_comb begin
    logic [6:0] logical;
    logic [6:0] edge_hit;
    logic [31:0] wval;
    logic [4:0] waddr;
    logic [4:0] raddr;
    logic inh_true;
    logic cond_any;
    logic fire;
    dcp_func_type f;
    logical = '0;
    edge_hit = '0;
    wval = '0;
    waddr = '0;
    raddr = '0;
    inh_true = 1'b0;
    cond_any = 1'b0;
    fire = 1'b0;
    f = general_bidir_function;
    next_s = s;
    next_s.clear_prot = 1'b0;
    next_s.sw_trig = 1'b0;
    next_s.trig_pulse = '0;

    // The stored inhibit mode is taken once, on the first cycle after reset.
    if (!s.mode_loaded) begin
      next_s.mode = dcp_block_mode_type'(nv_block_mode);
      next_s.mode_loaded = 1'b1;
    end

    // Three-stage pin synchroniser; a level counts once stages two and three agree.
    next_s.sync1 = pin_in;
    next_s.sync2 = s.sync1;
    next_s.sync3 = s.sync2;
    for (int i = 0; i < NUM_PINS; i++) begin
      if (s.sync2[i] == s.sync3[i]) begin
        next_s.lvl[i] = s.sync3[i];
      end
    end
    next_s.prev_lvl = s.lvl;
    logical = s.lvl ^ s.pol;

    // Write response completes; a new write may then be accepted.
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end

    // Performs a write once both address and data are held.
    if (s.aw_have && s.w_have && !s.bvalid) begin
      waddr = {s.aw_addr[4:2], 2'b00};
      next_s.aw_have = 1'b0;
      next_s.w_have = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = dcp_mapped(s.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      unique case (waddr)
        REG_FUNC: begin
          wval = dcp_merge({11'h000, s.func}, s.w_data, s.w_strb);
          next_s.func = wval[20:0];
        end
        REG_POL: begin
          wval = dcp_merge({25'h0000000, s.pol}, s.w_data, s.w_strb);
          next_s.pol = wval[6:0];
        end
        REG_DATA: begin
          wval = dcp_merge({25'h0000000, s.out_word}, s.w_data, s.w_strb);
          next_s.out_word = wval[6:0];
        end
        REG_BLOCK: begin
          wval = dcp_merge({30'h00000000, s.mode}, s.w_data, s.w_strb);
          next_s.mode = dcp_block_mode_type'(wval[BLK_MODE_LSB +: 2]);
          next_s.clear_prot = s.w_strb[0] & s.w_data[BLK_CLEAR_BIT];
        end
        REG_STATUS: begin
          // Write one to clear; hardware sets below take precedence.
          if (s.w_strb[0]) begin
            next_s.ques = s.ques & ~s.w_data[ST_QUES_BIT];
          end
          if (s.w_strb[1]) begin
            next_s.trig_sticky = s.trig_sticky & ~s.w_data[ST_TRIG_LSB +: NUM_PINS];
          end
        end
        REG_TRIG: begin
          next_s.sw_trig = s.w_strb[0] & s.w_data[TRIG_FIRE_BIT];
        end
        REG_CHAN: begin
          wval = dcp_merge(32'(s.chan_on), s.w_data, s.w_strb);
          next_s.chan_on = wval[NCH-1:0];
          // A channel switched on while blocked is held off.
          for (int c = 0; c < NCH; c++) begin
            if (wval[c] && !s.chan_on[c] && s.block) begin
              next_s.held[c] = 1'b1;
            end
          end
        end
        default: begin
        end
      endcase
    end

    // Address and data handshakes, taken in either order.
    if (s.awready && s_axi_awvalid) begin
      next_s.aw_have = 1'b1;
      next_s.aw_addr = s_axi_awaddr;
    end
    if (s.wready && s_axi_wvalid) begin
      next_s.w_have = 1'b1;
      next_s.w_data = s_axi_wdata;
      next_s.w_strb = s_axi_wstrb;
    end

    // Read channel: the answer appears one cycle after the address is taken.
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (s.arready && s_axi_arvalid) begin
      raddr = {s_axi_araddr[4:2], 2'b00};
      next_s.rvalid = 1'b1;
      next_s.rresp = dcp_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      next_s.rdata = '0;
      unique case (raddr)
        REG_FUNC: next_s.rdata = {11'h000, s.func};
        REG_POL: next_s.rdata = {25'h0000000, s.pol};
        REG_DATA: next_s.rdata = {25'h0000000, logical};
        REG_BLOCK: next_s.rdata = {30'h00000000, s.mode};
        REG_STATUS: begin
          next_s.rdata[ST_ERR_BIT] = s.err;
          next_s.rdata[ST_BLOCK_BIT] = s.block;
          next_s.rdata[ST_QUES_BIT] = s.ques;
          next_s.rdata[ST_LATCH_BIT] = s.inh_latch;
          next_s.rdata[ST_TRIGGER_OUT_FUNCTION_BIT] = s.tactive;
          next_s.rdata[ST_TRIG_LSB +: NUM_PINS] = s.trig_sticky;
        end
        REG_CHAN: next_s.rdata = 32'(s.chan_en);
        default: next_s.rdata = '0;
      endcase
    end

    // Trigger inputs: rising edge for positive polarity, falling for negative.
    for (int i = 0; i < NUM_PINS; i++) begin
      edge_hit[i] = s.pol[i] ? (s.prev_lvl[i] & ~s.lvl[i]) : (~s.prev_lvl[i] & s.lvl[i]);
      if (dcp_pin_func(s.func, i) == trigger_in_function && edge_hit[i]) begin
        next_s.trig_pulse[i] = 1'b1;
        next_s.trig_sticky[i] = 1'b1;
      end
    end

    // Trigger output timer: each event restarts one full-width pulse.
    fire = trig_event | s.sw_trig;
    if (fire) begin
      next_s.tactive = 1'b1;
      next_s.tcnt = TRIG_OUT_LOAD;
    end else if (s.tactive) begin
      if (s.tcnt == 8'h00) begin
        next_s.tactive = 1'b0;
      end else begin
        next_s.tcnt = s.tcnt - 8'h01;
      end
    end

    // Inhibit input exists only on pin 3.
    inh_true = (dcp_pin_func(s.func, PIN_BLOCK) == output_block_function) &&
               logical[PIN_BLOCK];
    next_s.prev_inh = inh_true;

    // Latch for latching mode; leaving that mode drops it at once.
    if (s.mode != block_latch) begin
      next_s.inh_latch = 1'b0;
    end else if (inh_true && !s.prev_inh) begin
      next_s.inh_latch = 1'b1;
    end else if (s.clear_prot) begin
      next_s.inh_latch = 1'b0;
    end

    // Output blocking by mode; an unknown mode code behaves as off.
    unique case (s.mode)
      block_live: next_s.block = inh_true;
      block_latch: next_s.block = next_s.inh_latch;
      default: next_s.block = 1'b0;
    endcase

    // Questionable inhibit bit is set by blocking and kept until written clear; the indicator follows blocking.
    if (next_s.block) begin
      next_s.ques = 1'b1;
    end

    // Channels already on are gated by blocking; held ones wait for a new switch-on.
    for (int c = 0; c < NCH; c++) begin
      if (!next_s.chan_on[c]) begin
        next_s.held[c] = 1'b0;
      end
    end
    next_s.chan_en = next_s.chan_on & ~next_s.held & {NCH{~next_s.block}};

    // Error latch: any cause sets it, a clear only acts once every cause is gone.
    cond_any = (|protect_cond) | power_fail | s.block;
    if (cond_any) begin
      next_s.err = 1'b1;
    end else if (s.clear_prot) begin
      next_s.err = 1'b0;
    end

    // Pin drivers by function, with polarity applied to every level driven here; the return pin below is driven low without it.
    for (int i = 0; i < NUM_PINS; i++) begin
      f = dcp_pin_func(s.func, i);
      next_s.pin_oe[i] = 1'b0;
      next_s.pin_out[i] = 1'b0;
      unique case (f)
        general_bidir_function: begin
          next_s.pin_oe[i] = 1'b1;
          next_s.pin_out[i] = s.out_word[i] ^ s.pol[i];
        end
        trigger_out_function: begin
          next_s.pin_oe[i] = 1'b1;
          next_s.pin_out[i] = next_s.tactive ^ s.pol[i];
        end
        error_out_function: begin
          if (i == PIN_ERROR) begin
            next_s.pin_oe[i] = 1'b1;
            next_s.pin_out[i] = next_s.err ^ s.pol[i];
          end
        end
        default: begin
          next_s.pin_oe[i] = 1'b0;
        end
      endcase
    end

    // Pin 2 becomes the return of the error pair, whatever it was set to.
    if (dcp_pin_func(s.func, PIN_ERROR) == error_out_function) begin
      next_s.pin_oe[PIN_RETURN] = 1'b1;
      next_s.pin_out[PIN_RETURN] = 1'b0;
    end

    // Ready flags are registered so that every port comes from a flip-flop.
    next_s.awready = !next_s.aw_have && !next_s.bvalid;
    next_s.wready = !next_s.w_have && !next_s.bvalid;
    next_s.arready = !next_s.rvalid;
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------

  // Registers the state; reset gives every field a constant.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.func <= FUNC_RST;
      s.pol <= POL_RST;
      s.out_word <= DATA_RST;
      s.mode <= block_off;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------

  // Every output is a field of the state register.
  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign pin_out = s.pin_out;
  assign pin_oe = s.pin_oe;
  assign block_mode = s.mode;
  assign trig_in_pulse = s.trig_pulse;
  assign chan_enable = s.chan_en;
  assign block_indicator = s.block;
  assign ques_block_bit = s.ques;
  assign error_signal = s.err;

endmodule : dcp_top

// ==== verification/dcp_assertions.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------------
module dcp_checker
  import dcp_pkg::*;
#(
  parameter int NCH = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [NCH-1:0] protect_cond,
  input wire logic power_fail,
  input wire logic [1:0] nv_block_mode,
  input wire logic [1:0] block_mode,
  input wire logic [NUM_PINS-1:0] trig_in_pulse,
  input wire logic [NCH-1:0] chan_enable,
  input wire logic block_indicator,
  input wire logic ques_block_bit,
  input wire logic error_signal
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Error latch, inhibit blocking and trigger pulse relations.
  chk_err_cause: assert property (((|protect_cond) || power_fail) |-> ##[1:3] error_signal)
    else $error("error signal missed a protection cause");
  chk_err_hold: assert property ((error_signal && ((|protect_cond) || power_fail)) |=> error_signal)
    else $error("error signal released while cause active");
  chk_err_block: assert property (block_indicator |-> ##[0:3] error_signal)
    else $error("blocking did not raise error signal");
  chk_block_ques: assert property (block_indicator |-> ##[0:2] ques_block_bit)
    else $error("blocking did not set questionable bit");
  chk_block_chan: assert property (block_indicator [*3] |-> chan_enable == '0)
    else $error("channel on while blocked");
  chk_trig_single: assert property (trig_in_pulse != '0 |=> (trig_in_pulse & $past(trig_in_pulse)) == '0)
    else $error("trigger in pulse longer than one cycle");
  chk_mode_off: assert property ((block_mode == 2'h0) [*3] |-> !block_indicator)
    else $error("blocking in off mode");
  chk_mode_nv: assert property ($rose(aresetn) |-> ##[1:2] block_mode == nv_block_mode)
    else $error("stored mode not restored");
endmodule : dcp_checker

bind dcp_top dcp_checker #(.NCH(NCH)) dcp_checker_inst (.aclk(aclk), .aresetn(aresetn),
  .protect_cond(protect_cond), .power_fail(power_fail), .nv_block_mode(nv_block_mode),
  .block_mode(block_mode), .trig_in_pulse(trig_in_pulse), .chan_enable(chan_enable),
  .block_indicator(block_indicator), .ques_block_bit(ques_block_bit),
  .error_signal(error_signal));

// ==== verification/dcp_pins.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Outside circuitry on the port pins
// ----------------------------------------------------------------------
module dcp_pins
  import dcp_pkg::*;
(
  input wire logic aclk,
  input wire logic [NUM_PINS-1:0] pin_out,
  input wire logic [NUM_PINS-1:0] pin_oe,
  output logic [NUM_PINS-1:0] pin_in
);
  logic [NUM_PINS-1:0] ext_en = 7'h1c;
  logic [NUM_PINS-1:0] ext_lvl = 7'h00;
  // A driven pin shows its driver, else the outside level, else the pull-up.
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : (ext_en[i] ? ext_lvl[i] : 1'b1);
    end
  end
  // Changes one outside level just after a clock edge.
  task automatic set_level(input int idx, input logic v);
    @(posedge aclk);
    ext_lvl[idx] <= v;
  endtask : set_level
endmodule : dcp_pins

// ==== verification/digital_control_port_test.sv ====
`timescale 1ns/1ps
module digital_control_port_test
  import dcp_pkg::*;
;
  // ----------------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------------
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, block_mode, r;
  logic [6:0] pin_in, pin_out, pin_oe, trig_in_pulse;
  logic [3:0] protect_cond = 4'h0, chan_enable;
  logic power_fail = 1'b0, trig_event = 1'b0;
  logic [1:0] nv_mode = 2'h2;
  logic block_indicator, ques_block_bit, error_signal;
  logic [31:0] d;
  int miscompares = 0, tests_run = 0, cnt;
  // Free-running 100 MHz clock.
  always #5 aclk = ~aclk;
  dcp_top #(.NCH(4)) dcp_top_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .protect_cond(protect_cond), .power_fail(power_fail),
    .trig_event(trig_event), .nv_block_mode(nv_mode), .block_mode(block_mode),
    .trig_in_pulse(trig_in_pulse), .chan_enable(chan_enable),
    .block_indicator(block_indicator), .ques_block_bit(ques_block_bit),
    .error_signal(error_signal));
  dcp_pins dcp_pins_inst (.aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));
  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : wait_cyc
  task automatic wr(input logic [4:0] a, input logic [31:0] v, input logic [1:0] exp);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        check("bresp", s_axi_bresp, exp);
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [31:0] exp, input logic [1:0] rexp);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        check("rdata", s_axi_rdata, exp);
        check("rresp", s_axi_rresp, rexp);
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask : rd
  task automatic count_trig(input int n);
    cnt = 0;
    repeat (n) begin
      @(posedge aclk);
      cnt += int'(trig_in_pulse[3]);
    end
  endtask : count_trig
  task automatic trig_width(input logic idle);
    cnt = 0;
    for (int n = 0; n < 50 && pin_out[5] === idle; n++) @(posedge aclk);
    while (pin_out[5] === !idle && cnt < 1000) begin
      cnt++;
      @(posedge aclk);
    end
  endtask : trig_width
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done
  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  // Main sequence.
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    wait_cyc(4);
    check("mode", block_mode, 2'h2);
    rd(REG_FUNC, 32'h0, RESP_OKAY);
    rd(REG_POL, 32'h0, RESP_OKAY);
    check("oe", pin_oe, 7'h7f);
    wr(REG_DATA, 32'h55, RESP_OKAY);
    wait_cyc(8);
    check("out", pin_out, 7'h55);
    rd(REG_DATA, 32'h55, RESP_OKAY);
    wr(REG_POL, 32'h0f, RESP_OKAY);
    wait_cyc(8);
    check("out pol", pin_out, 7'h5a);
    rd(REG_DATA, 32'h55, RESP_OKAY);
    wr(REG_POL, 32'h0, RESP_OKAY);
    wr(REG_DATA, 32'h40, RESP_OKAY); // Pin 3 idles low before it becomes the inhibit input.
    rd(5'h1c, 32'h0, RESP_SLVERR);
    wr(5'h1c, 32'h1, RESP_SLVERR);
    $display("test registers done");
    wr(REG_FUNC, 32'h19544, RESP_OKAY);
    wait_cyc(10);
    check("oe func", pin_oe, 7'h63);
    check("out func", pin_out & 7'h63, 7'h40);
    rd(REG_DATA, 32'h40, RESP_OKAY);
    dcp_pins_inst.set_level(4, 1'b1);
    wait_cyc(10);
    rd(REG_DATA, 32'h50, RESP_OKAY);
    $display("test input done");
    for (int p = 0; p < 2; p++) begin
      wr(REG_POL, 32'(p) << 3, RESP_OKAY);
      count_trig(20);
      dcp_pins_inst.set_level(3, 1'b1);
      count_trig(120);
      check("trig rise", cnt, 1 - p);
      dcp_pins_inst.set_level(3, 1'b0);
      count_trig(120);
      check("trig fall", cnt, p);
      wr(REG_POL, 32'(p) << 5, RESP_OKAY);
      wait_cyc(5);
      if (p == 0) begin
        trig_event <= 1'b1;
        @(posedge aclk);
        trig_event <= 1'b0;
      end else wr(REG_TRIG, 32'h1, RESP_OKAY);
      trig_width(p[0]);
      check("trig out", cnt, TRIG_OUT_CYC);
    end
    $display("test trigger done");
    for (int c = 0; c < 2; c++) begin
      protect_cond <= c ? 4'h0 : 4'h1;
      power_fail <= c[0];
      wait_cyc(5);
      check("err set", {pin_out[1:0], error_signal}, 3'h3);
      wr(REG_BLOCK, 32'h12, RESP_OKAY);
      wait_cyc(3);
      check("err busy", error_signal, 1'b1);
      protect_cond <= 4'h0;
      power_fail <= 1'b0;
      wait_cyc(5);
      check("err kept", error_signal, 1'b1);
      wr(REG_BLOCK, 32'h12, RESP_OKAY);
      wait_cyc(3);
      check("err clr", {pin_out[0], error_signal}, 2'h0);
    end
    $display("test error done");
    wr(REG_CHAN, 32'hf, RESP_OKAY);
    wait_cyc(3);
    check("chan on", chan_enable, 4'hf);
    dcp_pins_inst.set_level(2, 1'b1);
    wait_cyc(10);
    check("latch", {block_indicator, ques_block_bit, chan_enable}, 6'h30);
    rd(REG_STATUS, 32'h80f, RESP_OKAY);
    dcp_pins_inst.set_level(2, 1'b0);
    wait_cyc(10);
    check("latch held", chan_enable, 4'h0);
    wr(REG_BLOCK, 32'h12, RESP_OKAY);
    wait_cyc(5);
    check("latch clr", chan_enable, 4'hf);
    wr(REG_BLOCK, 32'h1, RESP_OKAY);
    wr(REG_CHAN, 32'h7, RESP_OKAY);
    check("mode live", block_mode, 2'h1);
    dcp_pins_inst.set_level(2, 1'b1);
    wait_cyc(10);
    check("live", chan_enable, 4'h0);
    wr(REG_CHAN, 32'hf, RESP_OKAY);
    dcp_pins_inst.set_level(2, 1'b0);
    wait_cyc(10);
    check("live end", chan_enable, 4'h7);
    rd(REG_CHAN, 32'h7, RESP_OKAY);
    wr(REG_BLOCK, 32'h0, RESP_OKAY);
    dcp_pins_inst.set_level(2, 1'b1);
    wait_cyc(10);
    check("off", {block_indicator, chan_enable}, 5'h07);
    wr(REG_STATUS, 32'h4, RESP_OKAY);
    wait_cyc(3);
    check("ques clr", ques_block_bit, 1'b0);
    $display("test inhibit done");
    // A second reset must pick up a different stored inhibit mode.
    nv_mode <= 2'h1;
    aresetn <= 1'b0;
    wait_cyc(4);
    aresetn <= 1'b1;
    wait_cyc(4);
    check("mode nv", {block_mode, chan_enable}, 6'h10);
    $display("test reset done");
    test_done();
  end
  // Cuts a hung run short.
  initial begin
    wait_cyc(20000);
    miscompares++;
    test_done();
  end
endmodule : digital_control_port_test
